/* File: pkg/pulse_gen_pkg.sv */
// Constants and types shared by the delayed pulse generator
package pulse_gen_pkg;

  // Widths
  localparam int CNT_W = 16;
  localparam int DIN_W = 32;
  localparam int PRE_W = 14;
  localparam int TB_W  = 3;

  // System clock and finest internal timebase
  localparam int CLK_FREQ_KHZ  = 20_000;
  localparam int BASE_TICK_NS  = 50;
  localparam int BASE_TICK_CYC = (BASE_TICK_NS * CLK_FREQ_KHZ + 999_999) / 1_000_000;

  // Internal timebases, as multiples of the base tick, finest first
  localparam int TB_COUNT = 5;
  localparam logic [TB_W-1:0] TB_LAST = 3'h4;
  localparam logic [PRE_W-1:0] TB0_RELOAD = PRE_W'(1 * BASE_TICK_CYC - 1);
  localparam logic [PRE_W-1:0] TB1_RELOAD = PRE_W'(10 * BASE_TICK_CYC - 1);
  localparam logic [PRE_W-1:0] TB2_RELOAD = PRE_W'(100 * BASE_TICK_CYC - 1);
  localparam logic [PRE_W-1:0] TB3_RELOAD = PRE_W'(1000 * BASE_TICK_CYC - 1);
  localparam logic [PRE_W-1:0] TB4_RELOAD = PRE_W'(10000 * BASE_TICK_CYC - 1);
  localparam logic [DIN_W-1:0] TB0_DIV    = 32'h0000_0001;
  localparam logic [DIN_W-1:0] TB1_DIV    = 32'h0000_000a;
  localparam logic [DIN_W-1:0] TB2_DIV    = 32'h0000_0064;
  localparam logic [DIN_W-1:0] TB3_DIV    = 32'h0000_03e8;
  localparam logic [DIN_W-1:0] TB4_DIV    = 32'h0000_2710;

  // Phase lengths
  localparam logic [DIN_W-1:0] CNT_MAX         = 32'h0000_ffff;
  localparam logic [CNT_W-1:0] MIN_DELAY_TICKS = 16'h0003;
  localparam logic [CNT_W-1:0] MIN_PHASE_TICKS = 16'h0001;

  // Gate qualifier settings
  typedef enum logic [2:0] {
    gate_ignored_sw_go,
    gate_count_high,
    gate_count_low,
    gate_start_rise,
    gate_start_fall,
    gate_restart_rise,
    gate_restart_fall
  } gate_mode_type;

  // Output level settings
  typedef enum logic {
    active_high_output,
    active_low_output
  } out_level_type;

  // Sequencer states
  typedef enum logic [1:0] {
    st_idle,
    st_armed,
    st_delay,
    st_pulse
  } phase_state_type;

endpackage

/* File: verif/gate_source_model.sv */
// Behavioural drivers for the external gate and count source pins
`timescale 1ns/10ps
module gate_source_model
(
  // Bench control
  input  wire logic clk_sys_i,
  input  wire logic src_run_i,
  input  wire logic gate_lvl_i,
  // Pins
  output wire logic source_o,
  output wire logic gate_o
);
  logic [2:0] phase_reg = 3'h0;

  // Source stands low outside bursts, period eight clocks, skewed off the edge
  always @(posedge clk_sys_i)
    phase_reg <= src_run_i ? phase_reg + 3'h1 : 3'h0;
  assign #11 source_o = phase_reg[2];
  assign #9 gate_o = gate_lvl_i;
endmodule

/* File: verif/pulse_gen_asserts.sv */
// Port-level checks for the delayed pulse generator
`timescale 1ns/10ps
module pulse_gen_asserts
  import pulse_gen_pkg::*;
(
  // Design inputs
  input wire logic             clk_sys_i,
  input wire logic             rstn_i,
  input wire logic             clk_en_i,
  input wire logic             start_i,
  input wire logic             stop_i,
  input wire logic [DIN_W-1:0] delay_phase_length_i,
  input wire logic [DIN_W-1:0] pulse_phase_length_i,
  input wire logic             count_clock_select_i,
  input wire gate_mode_type    gate_qualifier_select_i,
  input wire out_level_type    output_level_select_i,
  input wire logic             source_i,
  input wire logic             gate_i,
  // Design outputs
  input wire logic             pulse_o,
  input wire logic             busy_o,
  input wire logic             waiting_gate_o,
  input wire logic             pulse_phase_o,
  input wire logic [TB_W-1:0]  timebase_sel_o
);
  logic pol_reg;

  always_ff @(posedge clk_sys_i or negedge rstn_i)
    if (!rstn_i)
      pol_reg <= 1'b0;
    else if (start_i && clk_en_i && !stop_i)
      pol_reg <= output_level_select_i;

  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  sequence sw_go;
    start_i && clk_en_i && !stop_i;
  endsequence
  sequence zero_go;
    sw_go ##0 (delay_phase_length_i == '0 && pulse_phase_length_i <= CNT_MAX
      && !count_clock_select_i && gate_qualifier_select_i == gate_ignored_sw_go);
  endsequence

  go_busy_a: assert property (sw_go |=> busy_o)
    else $error("no busy after start");
  ungated_go_a: assert property (sw_go ##0 (gate_qualifier_select_i == gate_ignored_sw_go)
    |=> !waiting_gate_o) else $error("ungated start waits for gate");
  edge_arm_a: assert property (sw_go ##0 (gate_qualifier_select_i inside {[3'h3:3'h6]})
    |=> waiting_gate_o && !pulse_phase_o) else $error("edge mode not armed");
  zero_hold_a: assert property (zero_go |=> !pulse_phase_o [*3])
    else $error("zero delay shorter than three ticks");
  zero_end_a: assert property (zero_go ##1 (clk_en_i && !start_i && !stop_i) [*3]
    |=> pulse_phase_o) else $error("zero delay longer than three ticks");
  out_level_a: assert property (busy_o |-> pulse_o == (pulse_phase_o ^ pol_reg))
    else $error("output level wrong for phase");
  stop_idle_a: assert property (stop_i && clk_en_i |=> !busy_o && !pulse_phase_o)
    else $error("stop did not idle");
  ext_tb_a: assert property (sw_go ##0 count_clock_select_i |=> timebase_sel_o == '0)
    else $error("timebase not zero in external mode");
  wait_level_a: assert property (waiting_gate_o |-> !pulse_phase_o && pulse_o == pol_reg)
    else $error("armed output not at delay level");
endmodule

bind delayed_pulse_generator pulse_gen_asserts CHK (.*);

/* File: verif/test_delayed_pulse_generator.sv */
// Self-checking bench for the delayed pulse generator
`timescale 1ns/10ps
module test_delayed_pulse_generator;
  import pulse_gen_pkg::*;
  logic             clk_sys_i = 0, rstn_i = 0, clk_en_i = 1, start_i = 0, stop_i = 0;
  logic             count_clock_select_i = 0, src_run = 0, gate_lvl = 0;
  logic [DIN_W-1:0] delay_phase_length_i = '0, pulse_phase_length_i = '0;
  gate_mode_type    gate_qualifier_select_i = gate_ignored_sw_go;
  out_level_type    output_level_select_i = active_high_output;
  logic             source_i, gate_i, pulse_o, busy_o, waiting_gate_o, pulse_phase_o;
  logic [TB_W-1:0]  timebase_sel_o;
  int               error_cnt = 0, n_checks = 0, dc, wc, ref_dc, d, w, k;

  delayed_pulse_generator DUT (.*);
  gate_source_model PEER (.clk_sys_i, .src_run_i(src_run), .gate_lvl_i(gate_lvl),
                          .source_o(source_i), .gate_o(gate_i));

  initial forever #25 clk_sys_i = ~clk_sys_i;

  ////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  function automatic int tbk(int unsigned a, int unsigned b);
    int unsigned dv = 1;
    for (int i = 0; i < 4; i++)
    begin
      if (a / dv <= 65535 && b / dv <= 65535)
        return i;
      dv *= 10;
    end
    return 4;
  endfunction

  task automatic go(int d, int w, logic e, gate_mode_type m, out_level_type p, logic g);
    @(posedge clk_sys_i);
    delay_phase_length_i <= d;
    pulse_phase_length_i <= w;
    count_clock_select_i <= e;
    gate_qualifier_select_i <= m;
    output_level_select_i <= p;
    gate_lvl <= g;
    start_i <= 1'b1;
    @(posedge clk_sys_i);
    start_i <= 1'b0;
  endtask

  task automatic tick(int n, logic g);
    repeat (n) @(posedge clk_sys_i);
    gate_lvl <= g;
  endtask

  task automatic meas;
    dc = 0;
    wc = 0;
    while (pulse_phase_o !== 1'b1 && dc < 3000)
    begin
      @(posedge clk_sys_i);
      #1 dc++;
    end
    chk("pulse level", !output_level_select_i, pulse_o);
    while (pulse_phase_o !== 1'b0 && wc < 3000)
    begin
      @(posedge clk_sys_i);
      #1 wc++;
    end
    chk("delay level", output_level_select_i, pulse_o);
    if (dc >= 3000 || wc >= 3000)
    begin
      error_cnt++;
      $display("[ERR] phase wait expected done seen timeout");
      end_sim;
    end
  endtask

  task automatic stop_run;
    @(posedge clk_sys_i);
    stop_i <= 1'b1;
    @(posedge clk_sys_i);
    stop_i <= 1'b0;
    #1;
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h9313));
    repeat (8) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    #1 chk("reset out", 0, {busy_o, pulse_o, waiting_gate_o});
    // Ungated internal runs, zero lengths first, gate at random
    for (int i = 0; i < 8; i++)
    begin
      d = (i == 0) ? 0 : $urandom % 16;
      w = (i < 2) ? 0 : $urandom % 16;
      go(d, w, 0, gate_mode_type'(i % 2 * 7), out_level_type'($urandom % 2), 1'($urandom));
      meas;
      chk("delay cycles", (d == 0) ? 3 : d, dc);
      chk("width cycles", (w == 0) ? 1 : w, wc);
      chk("idle", 0, busy_o);
    end
    // Timebase boundaries on either length, then stop
    for (int i = 0; i < 10; i++)
    begin
      d = (i > 7) ? 700000000 : (65535 + i % 2) * (10 ** (i / 2));
      go(i % 2 ? 5 : d, i % 2 ? d : 5, 0, gate_ignored_sw_go, active_high_output, 0);
      @(posedge clk_sys_i);
      #1 chk("timebase", tbk(d, d), timebase_sel_o);
      stop_run;
      chk("stopped", 0, busy_o);
    end
    // Level modes held off, then released
    for (int i = 1; i < 3; i++)
    begin
      go(6, 5, 0, gate_mode_type'(i), active_low_output, i == 2);
      tick(30, i == 2);
      #1 chk("held off", 2'b11, {busy_o, pulse_o});
      tick(1, i == 1);
      meas;
      chk("width cycles", 5, wc);
    end
    // Edge start and restart modes
    for (int i = 3; i < 7; i++)
    begin
      k = (i == 4 || i == 6);
      go(20, 4, 0, gate_mode_type'(i), out_level_type'(i % 2), k);
      tick(10, k);
      #1 chk("armed", 1, waiting_gate_o);
      tick(1, !k);
      meas;
      ref_dc = dc;
      chk("width cycles", 4, wc);
      chk("rearmed", i > 4, waiting_gate_o);
      if (i > 4)
      begin
        tick(1, k);
        tick(6, !k);
        tick(6, k);
        tick(6, !k);
        meas;
        chk("restart delay", ref_dc, dc);
      end
    end
    // Clock enable low freezes a running delay
    go(4, 3, 0, gate_ignored_sw_go, active_high_output, 0);
    clk_en_i <= 1'b0;
    tick(20, 0);
    #1 chk("frozen", 2'b10, {busy_o, pulse_phase_o});
    @(posedge clk_sys_i);
    clk_en_i <= 1'b1;
    meas;
    chk("delay cycles", 4, dc);
    chk("width cycles", 3, wc);
    // External source counting
    tick(1, 0);
    src_run <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      w = 1 + $urandom % 4;
      go(1 + $urandom % 4, w, 1, gate_ignored_sw_go, active_high_output, 0);
      meas;
      chk("source width", w * 8, wc);
      chk("timebase", 0, timebase_sel_o);
    end
    end_sim;
  end
endmodule

/* File: verilog/delayed_pulse_generator.sv */
// Two-phase delayed pulse and gate-triggered pulse train generator
`timescale 1ns/10ps

// Notes on behaviour
// - Single delayed pulse or gated pulse train
// - Count down delay, then reload width and count
// - Choose finest timebase fitting delay and width
// - Zero internal delay lasts three timebase cycles
// - External mode counts source pin rising edges
// - Ungated mode ignores gate, starts on command
// - Level modes count only while gate qualifies
// - Edge-start modes wait for first gate edge
// - Restart modes restart sequence on each edge
// - Active high: low delay, high pulse
// - Active low: high delay, low pulse
module delayed_pulse_generator
  import pulse_gen_pkg::*;
(
  // Clock, reset, enable
  input  wire logic              clk_sys_i,
  input  wire logic              rstn_i,
  input  wire logic              clk_en_i,
  // Software control
  input  wire logic              start_i,
  input  wire logic              stop_i,
  input  wire logic [DIN_W-1:0]  delay_phase_length_i,
  input  wire logic [DIN_W-1:0]  pulse_phase_length_i,
  input  wire logic              count_clock_select_i,
  input  wire gate_mode_type     gate_qualifier_select_i,
  input  wire out_level_type     output_level_select_i,
  // Pins
  input  wire logic              source_i,
  input  wire logic              gate_i,
  output logic                   pulse_o,
  // Status
  output logic                   busy_o,
  output logic                   waiting_gate_o,
  output logic                   pulse_phase_o,
  output logic [TB_W-1:0]        timebase_sel_o
);

  ////////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    phase_state_type  state;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] delay_load;
    logic [CNT_W-1:0] width_load;
    logic [PRE_W-1:0] pre;
    logic [PRE_W-1:0] pre_load;
    logic [TB_W-1:0]  tb_sel;
    logic             ext_src;
    gate_mode_type    mode;
    out_level_type    level;
    logic             gate_s1;
    logic             gate_s2;
    logic             gate_prev;
    logic             src_s1;
    logic             src_s2;
    logic             src_prev;
    logic             out_lvl;
  } gen_state_type;

  localparam gen_state_type STATE_RST = '0;

  gen_state_type state_reg;
  gen_state_type state_next;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Length expressed in ticks of timebase sel
  function automatic logic [DIN_W-1:0] tb_quant(input logic [DIN_W-1:0] len,
                                                input logic [TB_W-1:0]  sel);
    logic [DIN_W-1:0] q;
    q = len;
    case (sel)
      3'h0:    q = len / TB0_DIV;
      3'h1:    q = len / TB1_DIV;
      3'h2:    q = len / TB2_DIV;
      3'h3:    q = len / TB3_DIV;
      3'h4:    q = len / TB4_DIV;
      default: q = len / TB4_DIV;
    endcase
    return q;
  endfunction

  function automatic logic [PRE_W-1:0] tb_reload(input logic [TB_W-1:0] sel);
    logic [PRE_W-1:0] r;
    r = TB4_RELOAD;
    case (sel)
      3'h0:    r = TB0_RELOAD;
      3'h1:    r = TB1_RELOAD;
      3'h2:    r = TB2_RELOAD;
      3'h3:    r = TB3_RELOAD;
      default: r = TB4_RELOAD;
    endcase
    return r;
  endfunction

  // Finest timebase in which both lengths fit the counter
  function automatic logic [TB_W-1:0] tb_pick(input logic [DIN_W-1:0] d,
                                              input logic [DIN_W-1:0] w);
    logic [TB_W-1:0] sel;
    sel = TB_LAST;
    for (int k = TB_COUNT - 1; k >= 0; k--)
    begin
      if (tb_quant(d, TB_W'(k)) <= CNT_MAX && tb_quant(w, TB_W'(k)) <= CNT_MAX)
      begin
        sel = TB_W'(k);
      end
    end
    return sel;
  endfunction

  // Counter load value: saturated, never zero
  function automatic logic [CNT_W-1:0] to_load(input logic [DIN_W-1:0] q,
                                               input logic [CNT_W-1:0] floor_val);
    logic [CNT_W-1:0] v;
    if (q > CNT_MAX)
    begin
      v = CNT_MAX[CNT_W-1:0];
    end
    else
    begin
      v = q[CNT_W-1:0];
    end
    if (q == '0)
    begin
      v = floor_val;
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    logic             gate_rise;
    logic             gate_fall;
    logic             gate_ok;
    logic             run_edge;
    logic             restart_edge;
    logic             tick;
    logic [TB_W-1:0]  sel;
    logic [DIN_W-1:0] dq;
    logic [DIN_W-1:0] wq;
    gate_rise    = 1'b0;
    gate_fall    = 1'b0;
    gate_ok      = 1'b1;
    run_edge     = 1'b0;
    restart_edge = 1'b0;
    tick         = 1'b0;
    sel          = '0;
    dq           = '0;
    wq           = '0;

    state_next = state_reg;

    // Pin synchronisers
    state_next.gate_s1   = gate_i;
    state_next.gate_s2   = state_reg.gate_s1;
    state_next.gate_prev = state_reg.gate_s2;
    state_next.src_s1    = source_i;
    state_next.src_s2    = state_reg.src_s1;
    state_next.src_prev  = state_reg.src_s2;

    gate_rise = state_reg.gate_s2 & ~state_reg.gate_prev;
    gate_fall = ~state_reg.gate_s2 & state_reg.gate_prev;

    case (state_reg.mode)
      gate_count_high:   gate_ok = state_reg.gate_s2;
      gate_count_low:    gate_ok = ~state_reg.gate_s2;
      gate_start_rise:   run_edge = gate_rise;
      gate_start_fall:   run_edge = gate_fall;
      gate_restart_rise: restart_edge = gate_rise;
      gate_restart_fall: restart_edge = gate_fall;
      default:           gate_ok = 1'b1;
    endcase

    // Count tick from the prescaler or the source pin
    if (state_reg.state == st_delay || state_reg.state == st_pulse)
    begin
      if (state_reg.ext_src)
      begin
        tick = gate_ok & state_reg.src_s2 & ~state_reg.src_prev;
      end
      else if (gate_ok)
      begin
        if (state_reg.pre == '0)
        begin
          tick = 1'b1;
          state_next.pre = state_reg.pre_load;
        end
        else
        begin
          state_next.pre = state_reg.pre - 1'b1;
        end
      end
    end

    case (state_reg.state)
      st_armed:
      begin
        if (run_edge || restart_edge)
        begin
          state_next.state = st_delay;
          state_next.count = state_reg.delay_load;
          state_next.pre   = state_reg.pre_load;
        end
      end
      st_delay:
      begin
        if (restart_edge)
        begin
          state_next.count = state_reg.delay_load;
          state_next.pre   = state_reg.pre_load;
        end
        else if (tick)
        begin
          if (state_reg.count <= MIN_PHASE_TICKS)
          begin
            state_next.state = st_pulse;
            state_next.count = state_reg.width_load;
          end
          else
          begin
            state_next.count = state_reg.count - 1'b1;
          end
        end
      end
      st_pulse:
      begin
        if (restart_edge)
        begin
          state_next.state = st_delay;
          state_next.count = state_reg.delay_load;
          state_next.pre   = state_reg.pre_load;
        end
        else if (tick)
        begin
          if (state_reg.count <= MIN_PHASE_TICKS)
          begin
            if (state_reg.mode == gate_restart_rise || state_reg.mode == gate_restart_fall)
            begin
              state_next.state = st_armed;
            end
            else
            begin
              state_next.state = st_idle;
            end
          end
          else
          begin
            state_next.count = state_reg.count - 1'b1;
          end
        end
      end
      default:
      begin
        state_next.state = st_idle;
      end
    endcase

    // Software start latches the configuration
    if (start_i)
    begin
      sel = count_clock_select_i ? '0 : tb_pick(delay_phase_length_i,
                                                pulse_phase_length_i);
      dq  = count_clock_select_i ? delay_phase_length_i : tb_quant(delay_phase_length_i, sel);
      wq  = count_clock_select_i ? pulse_phase_length_i : tb_quant(pulse_phase_length_i, sel);
      state_next.tb_sel     = sel;
      state_next.ext_src    = count_clock_select_i;
      state_next.mode       = gate_qualifier_select_i;
      state_next.level      = output_level_select_i;
      state_next.pre_load   = tb_reload(sel);
      state_next.pre        = tb_reload(sel);
      state_next.width_load = to_load(wq, MIN_PHASE_TICKS);
      if (!count_clock_select_i && delay_phase_length_i == '0)
      begin
        state_next.delay_load = MIN_DELAY_TICKS;
      end
      else
      begin
        state_next.delay_load = to_load(dq, MIN_PHASE_TICKS);
      end
      state_next.count = state_next.delay_load;
      case (gate_qualifier_select_i)
        gate_start_rise, gate_start_fall, gate_restart_rise, gate_restart_fall:
          state_next.state = st_armed;
        default:
          state_next.state = st_delay;
      endcase
    end

    if (stop_i)
    begin
      state_next.state = st_idle;
    end

    // Output level follows the phase and the chosen polarity
    state_next.out_lvl = (state_next.state == st_pulse) ^
                         (state_next.level == active_low_output);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_reg <= STATE_RST;
    end
    else if (clk_en_i)
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign pulse_o        = state_reg.out_lvl;
  assign busy_o         = state_reg.state != st_idle;
  assign waiting_gate_o = state_reg.state == st_armed;
  assign pulse_phase_o  = state_reg.state == st_pulse;
  assign timebase_sel_o = state_reg.tb_sel;

endmodule
